// file: src/acs_axis.sv
// one axis: correction, vibration suppression, synchronised start
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - correction emits amount pulses at correction rate
// - backlash corrects on each direction reversal
// - slip corrects before every operation
// - correction amount is twelve bits, 0..4095
// - method field: none, backlash, slip
// - per-counter correction enables at bits 19..16
// - after command pulses, one reverse, one forward
// - suppression only when both times nonzero
// - factor 11 starts on stop of axes
// - factor 10 starts on source sync pulse
// - four-bit mask picks stop-trigger axes
// - sync output timing: comparators or phases
// - two-bit field picks sync source axis
// - sync emission raises event factor, interrupt
// - start when one stops, others stopped
// - only moving-to-stopped edges trigger start
// - preregisters chain next operation without stop
// - external start input releases waiting axis
module acs_axis (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire acs_pkg::acs_wr_s  host_wr,
  input  wire logic              rd_en,
  input  wire logic [3:0]        rd_sel,
  output logic [31:0]            rd_data,
  input  wire logic              ext_sync_start_in_n,
  input  wire logic [4:0]        cmp_hit,
  input  wire logic [3:0]        axis_running,
  input  wire logic [3:0]        sync_bus,
  output acs_pkg::acs_pulse_s    motor,
  output logic                   sync_out,
  output logic                   irq_out,
  output logic                   running_out
);

  typedef struct packed {
    acs_pkg::acs_state_e st;
    logic [11:0]         corr_amt;
    logic [1:0]          meth;
    logic [3:0]          cu_en;
    logic [31:0]         mode;
    logic [31:0]         sync_env;
    logic [15:0]         rt;
    logic [15:0]         ft;
    logic [15:0]         corr_rate;
    logic [15:0]         hs_rate;
    logic [27:0]         target;
    logic [31:0]         irq_en;
    logic [27:0]         nxt_target;
    logic [31:0]         nxt_mode;
    logic                nxt_valid;
    logic [27:0]         left;
    logic [11:0]         corr_left;
    logic                dir;
    logic                last_dir;
    logic                moved;
    logic [15:0]         wait_cnt;
    logic [3:0]          run_prev;
    logic [3:0]          phase;
    logic [31:0]         evt_factor;
    logic [31:0]         rd_data;
    acs_pkg::acs_pulse_s motor;
    logic                sync_out;
    logic                irq;
    logic                running;
  } acs_axis_s;

  acs_axis_s s_r;
  acs_axis_s s_nxt;

  logic ext_start_n;
  logic corr_tick;
  logic cmd_tick;

  acs_sync2 u_ext_sync (
    .clock (clock),
    .reset (reset),
    .d     (ext_sync_start_in_n),
    .q     (ext_start_n)
  );

  acs_rate_div u_corr_div (
    .clock  (clock),
    .reset  (reset),
    .run    (s_r.st == acs_pkg::ST_CORR),
    .period (s_r.corr_rate),
    .tick   (corr_tick)
  );

  acs_rate_div u_cmd_div (
    .clock  (clock),
    .reset  (reset),
    .run    (s_r.st == acs_pkg::ST_CMD),
    .period (s_r.hs_rate),
    .tick   (cmd_tick)
  );

  // leave any wait and begin pulse output
  function automatic acs_axis_s go_move(input acs_axis_s s);
    acs_axis_s o;
    logic      need;
    o    = s;
    need = 1'b0;
    if (s.meth == acs_pkg::METH_SLIP)
      need = 1'b1;
    else if (s.meth == acs_pkg::METH_BACK)
      need = s.moved && (s.dir != s.last_dir);
    o.moved    = 1'b1;
    o.last_dir = s.dir;
    if (need && s.corr_amt != 12'h000)
    begin
      o.st        = acs_pkg::ST_CORR;
      o.corr_left = s.corr_amt;
    end
    else
    begin
      o.st       = acs_pkg::ST_CMD;
      o.phase[0] = 1'b1;
      o.phase[1] = 1'b1;
    end
    return o;
  endfunction

  // take mode and target, then wait for the chosen start factor; factor 00 moves at once
  function automatic acs_axis_s launch(input acs_axis_s s);
    acs_axis_s o;
    o      = s;
    o.dir  = s.target[27];
    o.left = s.target[27] ? 28'(-s.target) : s.target;
    case (s.mode[acs_pkg::MSY_LSB +: 2])
      // hold for the external start input
      acs_pkg::SYF_EXT:  o.st = acs_pkg::ST_WAIT_EXT;
      acs_pkg::SYF_INT:  o.st = acs_pkg::ST_WAIT_SYNC;
      acs_pkg::SYF_STOP: o.st = acs_pkg::ST_WAIT_STOP;
      default:           o = go_move(o);
    endcase
    return o;
  endfunction

  // end of operation: chain preregisters or stop
  function automatic acs_axis_s finish(input acs_axis_s s);
    acs_axis_s o;
    o = s;
    // continue into the next operation with no stop
    if (s.nxt_valid)
    begin
      o.mode      = s.nxt_mode;
      o.target    = s.nxt_target;
      o.nxt_valid = 1'b0;
      o           = launch(o);
    end
    else
      o.st = acs_pkg::ST_IDLE;
    return o;
  endfunction

  logic [3:0]  stop_edge;
  logic [3:0]  axis_mask;
  logic [3:0]  syo;
  logic        sync_hit;
  logic [31:0] status;

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.motor    = '0;
    s_nxt.phase    = 4'h0;
    s_nxt.run_prev = axis_running;
    axis_mask      = s_r.mode[acs_pkg::MAX_LSB +: 4];
    stop_edge      = s_r.run_prev & ~axis_running & axis_mask;
    syo            = s_r.sync_env[acs_pkg::SYO_LSB +: 4];
    status         = 32'h0000_0000;

    // register writes
    if (host_wr.en)
    begin
      case (host_wr.sel)
        acs_pkg::SEL_CORR_ENV:
        begin
          s_nxt.corr_amt = host_wr.data[acs_pkg::AMT_LSB +: 12];
          s_nxt.meth     = host_wr.data[acs_pkg::METH_LSB +: 2];
        end
        acs_pkg::SEL_CNT_ENV:
          s_nxt.cu_en = host_wr.data[acs_pkg::CUEN_LSB +: 4];
        acs_pkg::SEL_OP_MODE:     s_nxt.mode     = host_wr.data;
        acs_pkg::SEL_SYNC_ENV:    s_nxt.sync_env = host_wr.data;
        acs_pkg::SEL_VIB_ENV:
        begin
          s_nxt.rt = host_wr.data[acs_pkg::RT_LSB +: 16];
          s_nxt.ft = host_wr.data[acs_pkg::FT_LSB +: 16];
        end
        acs_pkg::SEL_CORR_RATE:   s_nxt.corr_rate = host_wr.data[15:0];
        acs_pkg::SEL_HS_RATE:     s_nxt.hs_rate   = host_wr.data[15:0];
        acs_pkg::SEL_TARGET:      s_nxt.target    = host_wr.data[27:0];
        acs_pkg::SEL_IRQ_EN:      s_nxt.irq_en    = host_wr.data;
        acs_pkg::SEL_NEXT_TARGET: s_nxt.nxt_target = host_wr.data[27:0];
        acs_pkg::SEL_NEXT_MODE:   s_nxt.nxt_mode  = host_wr.data;
        acs_pkg::SEL_START:
        begin
          // a start while busy queues the preregisters
          if (s_r.st != acs_pkg::ST_IDLE)
            s_nxt.nxt_valid = 1'b1;
          else
            s_nxt = launch(s_nxt);
        end
        default: ;
      endcase
    end

    case (s_r.st)
      acs_pkg::ST_IDLE: ;
      // active-low start input releases the axis
      acs_pkg::ST_WAIT_EXT:
        if (!ext_start_n)
          s_nxt = go_move(s_nxt);
      acs_pkg::ST_WAIT_SYNC:
        if (sync_bus[s_r.sync_env[acs_pkg::SYI_LSB +: 2]])
          s_nxt = go_move(s_nxt);
      // one selected stops, all selected stopped
      acs_pkg::ST_WAIT_STOP:
        // only a falling running level counts
        if (stop_edge != 4'h0 && (axis_running & axis_mask) == 4'h0)
          s_nxt = go_move(s_nxt);
      acs_pkg::ST_CORR:
        if (corr_tick)
        begin
          s_nxt.motor.pulse     = 1'b1;
          s_nxt.motor.dir_minus = s_r.dir;
          s_nxt.motor.cnt_step  = s_r.cu_en;
          s_nxt.corr_left       = 12'(s_r.corr_left - 12'h001);
          // command starts after the last correction
          if (s_r.corr_left == 12'h001)
          begin
            s_nxt.st       = acs_pkg::ST_CMD;
            s_nxt.phase[0] = 1'b1;
            s_nxt.phase[1] = 1'b1;
          end
        end
      acs_pkg::ST_CMD:
        if (s_r.left == 28'h000_0000 || cmd_tick)
        begin
          if (s_r.left != 28'h000_0000)
          begin
            s_nxt.motor.pulse     = 1'b1;
            s_nxt.motor.dir_minus = s_r.dir;
            s_nxt.motor.cnt_step  = 4'hf;
            s_nxt.left            = 28'(s_r.left - 28'h000_0001);
          end
          if (s_r.left <= 28'h000_0001)
          begin
            s_nxt.phase[2] = 1'b1;
            s_nxt.phase[3] = 1'b1;
            if (s_r.rt != 16'h0000 && s_r.ft != 16'h0000)
            begin
              s_nxt.st       = acs_pkg::ST_VIB_REV;
              s_nxt.wait_cnt = s_r.rt;
            end
            else
              s_nxt = finish(s_nxt);
          end
        end
      acs_pkg::ST_VIB_REV:
        if (s_r.wait_cnt == 16'h0001)
        begin
          s_nxt.motor.pulse     = 1'b1;
          s_nxt.motor.dir_minus = ~s_r.dir;
          s_nxt.motor.cnt_step  = 4'hf;
          s_nxt.wait_cnt        = s_r.ft;
          s_nxt.st              = acs_pkg::ST_VIB_FWD;
        end
        else
          s_nxt.wait_cnt = 16'(s_r.wait_cnt - 16'h0001);
      acs_pkg::ST_VIB_FWD:
        if (s_r.wait_cnt == 16'h0001)
        begin
          s_nxt.motor.pulse     = 1'b1;
          s_nxt.motor.dir_minus = s_r.dir;
          s_nxt.motor.cnt_step  = 4'hf;
          s_nxt                 = finish(s_nxt);
        end
        else
          s_nxt.wait_cnt = 16'(s_r.wait_cnt - 16'h0001);
      default: s_nxt.st = acs_pkg::ST_IDLE;
    endcase

    // pick the event that emits the sync pulse
    sync_hit = 1'b0;
    if (syo >= acs_pkg::SYO_CMP1 && syo <= acs_pkg::SYO_CMP5)
      sync_hit = cmp_hit[3'(syo - acs_pkg::SYO_CMP1)];
    else if (syo >= acs_pkg::SYO_ACC_S && syo <= acs_pkg::SYO_DEC_E)
      sync_hit = s_r.phase[2'(syo - acs_pkg::SYO_ACC_S)];
    s_nxt.sync_out = sync_hit;

    status[acs_pkg::STS_WAIT_EXT]  = s_r.st == acs_pkg::ST_WAIT_EXT;
    status[acs_pkg::STS_WAIT_SYNC] = s_r.st == acs_pkg::ST_WAIT_SYNC;
    status[acs_pkg::STS_WAIT_STOP] = s_r.st == acs_pkg::ST_WAIT_STOP;
    status[acs_pkg::STS_CORR]      = s_r.st == acs_pkg::ST_CORR;
    status[acs_pkg::STS_VIB]       = s_r.st == acs_pkg::ST_VIB_REV ||
                                     s_r.st == acs_pkg::ST_VIB_FWD;
    status[acs_pkg::STS_RUN]       = s_r.st != acs_pkg::ST_IDLE;
    status[acs_pkg::STS_NEXT]      = s_r.nxt_valid;

    // reads; event factor clears on read
    if (rd_en)
    begin
      case (rd_sel)
        acs_pkg::SEL_EVT_FACTOR:
        begin
          s_nxt.rd_data    = s_r.evt_factor;
          s_nxt.evt_factor = 32'h0000_0000;
        end
        acs_pkg::SEL_EXT_STATUS: s_nxt.rd_data = status;
        default:                 s_nxt.rd_data = 32'h0000_0000;
      endcase
    end

    // sync emission sets the factor; set beats clear
    if (sync_hit && s_r.irq_en[acs_pkg::IRQ_SYNC_BIT])
      s_nxt.evt_factor[acs_pkg::IRQ_SYNC_BIT] = 1'b1;
    s_nxt.irq = s_nxt.evt_factor != 32'h0000_0000;
    s_nxt.running = s_nxt.st != acs_pkg::ST_IDLE;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_r           <= '0;
      s_r.st        <= acs_pkg::ST_IDLE;
      s_r.mode      <= acs_pkg::RST_WORD;
      s_r.corr_rate <= acs_pkg::RST_RATE;
      s_r.hs_rate   <= acs_pkg::RST_RATE;
    end
    else
      s_r <= s_nxt;
  end

  assign rd_data     = s_r.rd_data;
  assign motor       = s_r.motor;
  assign sync_out    = s_r.sync_out;
  assign irq_out     = s_r.irq;
  assign running_out = s_r.running;
endmodule // acs_axis
`default_nettype wire

// file: src/acs_pkg.sv
// package: constants and types of the axis correction and sync-start block
package acs_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;

  // register selects on the write/read port
  localparam logic [3:0] SEL_CORR_ENV    = 4'h0;
  localparam logic [3:0] SEL_CNT_ENV     = 4'h1;
  localparam logic [3:0] SEL_OP_MODE     = 4'h2;
  localparam logic [3:0] SEL_SYNC_ENV    = 4'h3;
  localparam logic [3:0] SEL_VIB_ENV     = 4'h4;
  localparam logic [3:0] SEL_CORR_RATE   = 4'h5;
  localparam logic [3:0] SEL_HS_RATE     = 4'h6;
  localparam logic [3:0] SEL_TARGET      = 4'h7;
  localparam logic [3:0] SEL_IRQ_EN      = 4'h8;
  localparam logic [3:0] SEL_NEXT_TARGET = 4'h9;
  localparam logic [3:0] SEL_NEXT_MODE   = 4'ha;
  localparam logic [3:0] SEL_START       = 4'hb;
  localparam logic [3:0] SEL_EVT_FACTOR  = 4'hc;
  localparam logic [3:0] SEL_EXT_STATUS  = 4'hd;

  // field positions
  localparam int AMT_LSB  = 0;
  localparam int METH_LSB = 12;
  localparam int CUEN_LSB = 16;
  localparam int MSY_LSB  = 18;
  localparam int MAX_LSB  = 20;
  localparam int SYO_LSB  = 16;
  localparam int SYI_LSB  = 20;
  localparam int RT_LSB   = 0;
  localparam int FT_LSB   = 16;
  localparam int IRQ_SYNC_BIT = 13;

  // extension status bit positions
  localparam int STS_WAIT_EXT  = 0;
  localparam int STS_WAIT_SYNC = 1;
  localparam int STS_WAIT_STOP = 2;
  localparam int STS_CORR      = 3;
  localparam int STS_VIB       = 4;
  localparam int STS_RUN       = 5;
  localparam int STS_NEXT      = 6;

  // field codes
  localparam logic [1:0] METH_NONE  = 2'h0;
  localparam logic [1:0] METH_BACK  = 2'h1;
  localparam logic [1:0] METH_SLIP  = 2'h2;
  localparam logic [1:0] SYF_EXT    = 2'h1;
  localparam logic [1:0] SYF_INT    = 2'h2;
  localparam logic [1:0] SYF_STOP   = 2'h3;
  localparam logic [3:0] SYO_CMP1   = 4'h1;
  localparam logic [3:0] SYO_CMP5   = 4'h5;
  localparam logic [3:0] SYO_ACC_S  = 4'h8;
  localparam logic [3:0] SYO_DEC_E  = 4'hb;

  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] RST_RATE  = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_EXT, ST_WAIT_SYNC, ST_WAIT_STOP,
    ST_CORR, ST_CMD, ST_VIB_REV, ST_VIB_FWD
  } acs_state_e;

  typedef struct packed {
    logic        en;
    logic [3:0]  sel;
    logic [31:0] data;
  } acs_wr_s;

  typedef struct packed {
    logic       pulse;
    logic       dir_minus;
    logic [3:0] cnt_step;
  } acs_pulse_s;

endpackage

// file: src/acs_rate_div.sv
// rate divider: one-cycle tick every period cycles while run is high
`timescale 1ns/1ps
`default_nettype none
module acs_rate_div (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output logic             tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } acs_div_s;

  acs_div_s s_r;
  acs_div_s s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!run)
      s_nxt.cnt = 16'h0000;
    // zero period behaves as one
    else if (16'(s_r.cnt + 16'h0001) >= period)
    begin
      s_nxt.cnt  = 16'h0000;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick & run;
endmodule // acs_rate_div
`default_nettype wire

// file: src/acs_sync2.sv
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module acs_sync2 (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic meta;
    logic stable;
  } acs_sync_s;

  acs_sync_s s_r;
  acs_sync_s s_nxt;

  always_comb
  begin
    s_nxt.meta   = d;
    s_nxt.stable = s_r.meta;
  end

  // idle level of an active-low pin is high
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s_r <= 2'b11;
    else
      s_r <= s_nxt;
  end

  assign q = s_r.stable;
endmodule // acs_sync2
`default_nettype wire

// file: test/acs_axis_properties.sv
// checker: port assertions of one axis
`timescale 1ns/1ps
`default_nettype none
module acs_axis_properties (
  input wire logic                clock,
  input wire logic                reset,
  input wire acs_pkg::acs_wr_s    host_wr,
  input wire logic                rd_en,
  input wire logic [31:0]         rd_data,
  input wire logic [4:0]          cmp_hit,
  input wire acs_pkg::acs_pulse_s motor,
  input wire logic                sync_out,
  input wire logic                irq_out,
  input wire logic                running_out
);
  logic [3:0] syo_r;
  logic       ien_r;

  // shadow of sync timing and irq enable
  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      syo_r <= 4'h0;
      ien_r <= 1'b0;
    end
    else if (host_wr.en)
    begin
      if (host_wr.sel == acs_pkg::SEL_SYNC_ENV)
        syo_r <= host_wr.data[19:16];
      if (host_wr.sel == acs_pkg::SEL_IRQ_EN)
        ien_r <= host_wr.data[13];
    end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_sync_pulse;
    sync_out |=> !sync_out;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync pulse longer than one cycle");
  property p_cmp_sync;
    (syo_r >= 4'h1 && syo_r <= 4'h5 && cmp_hit[syo_r - 4'h1]) |=> sync_out;
  endproperty
  a_cmp_sync: assert property (p_cmp_sync)
    else $error("comparator hit gave no sync");
  property p_sync_gate;
    sync_out |-> syo_r inside {[4'h1:4'h5], [4'h8:4'hb]};
  endproperty
  a_sync_gate: assert property (p_sync_gate)
    else $error("sync with no timing selected");
  property p_irq_set;
    (sync_out && ien_r) |-> irq_out;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("irq missing at sync");
  property p_irq_cause;
    $rose(irq_out) |-> sync_out;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose without sync");
  // irq clears only by a read
  property p_irq_clear;
    $fell(irq_out) |-> ($past(rd_en) || $past(rd_en, 2));
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("irq fell without read");
  property p_rd_hold;
    !$past(rd_en) |-> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  property p_step_pulse;
    (motor.cnt_step != 4'h0) |-> motor.pulse;
  endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("counter strobe without pulse");
  property p_pulse_busy;
    motor.pulse |-> $past(running_out);
  endproperty
  a_pulse_busy: assert property (p_pulse_busy)
    else $error("pulse while idle");
  property p_start_run;
    (host_wr.en && host_wr.sel == acs_pkg::SEL_START && !running_out)
      |=> running_out;
  endproperty
  a_start_run: assert property (p_start_run)
    else $error("start did not leave idle");

  c_sync: cover property (sync_out);
  c_irq_clr: cover property ($fell(irq_out));
  c_minus: cover property (motor.pulse && motor.dir_minus);
endmodule // acs_axis_properties

bind acs_axis acs_axis_properties u_props (
  .clock(clock), .reset(reset), .host_wr(host_wr), .rd_en(rd_en),
  .rd_data(rd_data), .cmp_hit(cmp_hit), .motor(motor),
  .sync_out(sync_out), .irq_out(irq_out), .running_out(running_out)
);
`default_nettype wire

// file: test/acs_motor_model.sv
// motor driver model: turns pulses into a position
`timescale 1ns/1ps
`default_nettype none
module acs_motor_model (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire acs_pkg::acs_pulse_s motor,
  output logic signed [31:0]       position
);
  // one count per pulse, sign from direction
  always_ff @(posedge clock or posedge reset)
    if (reset)
      position <= 32'sh0000_0000;
    else if (motor.pulse)
      position <= position + (motor.dir_minus ? -32'sh1 : 32'sh1);
endmodule // acs_motor_model
`default_nettype wire

// file: test/test_acs_axis.sv
// bench: drives one axis, scores pulses, sync and reads
`timescale 1ns/1ps
`default_nettype none
module test_acs_axis;
  logic                clock = 1'b0;
  logic                reset = 1'b1;
  acs_pkg::acs_wr_s    host_wr = '0;
  logic                rd_en = 1'b0;
  logic [3:0]          rd_sel = 4'h0;
  logic [31:0]         rd_data;
  logic                pin_n = 1'b1;
  logic [4:0]          cmp_hit = 5'h00;
  logic [3:0]          axis_running = 4'h0;
  logic [3:0]          sync_bus = 4'h0;
  acs_pkg::acs_pulse_s motor;
  logic                sync_out;
  logic                irq_out;
  logic                running_out;
  logic signed [31:0]  position;
  logic [4:0]          exp_q[$];
  logic [31:0]         seed = 32'h0000_bdbf;
  int                  n_mismatch = 0;
  int                  comparisons = 0;
  int                  sync_cnt = 0;
  int                  exp_pos = 0;

  always #10 clock = ~clock;

  acs_axis DUT (
    .clock(clock), .reset(reset), .host_wr(host_wr), .rd_en(rd_en),
    .rd_sel(rd_sel), .rd_data(rd_data), .ext_sync_start_in_n(pin_n),
    .cmp_hit(cmp_hit), .axis_running(axis_running), .sync_bus(sync_bus),
    .motor(motor), .sync_out(sync_out), .irq_out(irq_out),
    .running_out(running_out)
  );
  acs_motor_model u_motor (
    .clock(clock), .reset(reset), .motor(motor), .position(position)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [3:0] sel, input logic [31:0] d);
    @(negedge clock);
    host_wr = '{1'b1, sel, d};
    @(negedge clock);
    host_wr.en = 1'b0;
  endtask

  task automatic rd(input logic [3:0] sel, input int b, input logic exp);
    @(negedge clock);
    rd_en = 1'b1;
    rd_sel = sel;
    @(negedge clock);
    rd_en = 1'b0;
    check("rd_data bit", rd_data[b], exp);
  endtask

  task automatic push(input logic dm, input logic [3:0] st, input int n);
    repeat (n)
      exp_q.push_back({dm, st});
    exp_pos += dm ? -n : n;
  endtask

  task automatic idle_wait;
    int i;
    for (i = 0; i < 30000 && running_out !== 1'b0; i++)
      @(negedge clock);
    if (i == 30000)
    begin
      check("idle wait", 32'h0000_0000, 32'h0000_0001);
      tally_and_finish;
    end
    repeat (3)
      @(negedge clock);
  endtask

  task automatic arm(input logic [31:0] tgt, input logic [31:0] md,
                     input logic dm, input int nm, input logic nv);
    wr(acs_pkg::SEL_TARGET, tgt);
    wr(acs_pkg::SEL_OP_MODE, md);
    push(dm, 4'hf, nm);
    if (nv)
    begin
      push(~dm, 4'hf, 1);
      push(dm, 4'hf, 1);
    end
    wr(acs_pkg::SEL_START, 32'h0000_0000);
  endtask

  task automatic move(input logic [1:0] meth, input logic [11:0] amt,
                      input logic [31:0] tgt, input logic [31:0] md,
                      input int nc, input int nm, input logic dm,
                      input logic nv);
    wr(acs_pkg::SEL_CORR_ENV, {18'h0, meth, amt});
    push(dm, 4'h5, nc);
    arm(tgt, md, dm, nm, nv);
    idle_wait;
  endtask

  // scoreboard: oldest note against each pulse
  always @(posedge clock)
    if (motor.pulse === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare pulse", 32'h0000_0001, 32'h0000_0000);
      else
        check("pulse", {motor.dir_minus, motor.cnt_step},
              exp_q.pop_front());
    end

  always @(posedge clock)
    if (sync_out === 1'b1)
      sync_cnt++;

  initial
  begin
    int k;
    int e;
    repeat (16)
      @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    seed = lfsr(seed);
    wr(acs_pkg::SEL_CORR_RATE, {30'h0, seed[1:0]} + 32'h1);
    seed = lfsr(seed);
    wr(acs_pkg::SEL_HS_RATE, {30'h0, seed[1:0]} + 32'h1);
    wr(acs_pkg::SEL_CNT_ENV, 32'h0005_0000);
    // slip before two moves, largest amount first, then backlash
    move(2'h2, 12'hfff, 32'h1, 32'h41, 4095, 1, 1'b0, 1'b0);
    move(2'h2, 12'h003, 32'h2, 32'h41, 3, 2, 1'b0, 1'b0);
    move(2'h1, 12'h003, 32'h0fff_fffe, 32'h49, 3, 2, 1'b1, 1'b0);
    move(2'h1, 12'h003, 32'h0fff_ffff, 32'h49, 0, 1, 1'b1, 1'b0);
    move(2'h1, 12'h003, 32'h1, 32'h41, 3, 1, 1'b0, 1'b0);
    // suppression pair, then one time zero
    wr(acs_pkg::SEL_VIB_ENV, 32'h0004_0004);
    move(2'h0, 12'h003, 32'h1, 32'h41, 0, 1, 1'b0, 1'b1);
    wr(acs_pkg::SEL_VIB_ENV, 32'h0000_0004);
    move(2'h0, 12'h003, 32'h1, 32'h41, 0, 1, 1'b0, 1'b0);
    arm(32'h1, 32'h0004_0064, 1'b0, 1, 1'b0);
    repeat (8)
      @(negedge clock);
    rd(acs_pkg::SEL_EXT_STATUS, acs_pkg::STS_WAIT_EXT, 1'b1);
    check("queue", exp_q.size(), 1);
    pin_n = 1'b0;
    idle_wait;
    pin_n = 1'b1;
    // arm first, then start on stop of x and y
    arm(32'h1, 32'h003c_0041, 1'b0, 1, 1'b0);
    repeat (5)
      @(negedge clock);
    rd(acs_pkg::SEL_EXT_STATUS, acs_pkg::STS_WAIT_STOP, 1'b1);
    seed = lfsr(seed);
    axis_running = {seed[3:2], 2'b11};
    repeat (5)
      @(negedge clock);
    axis_running[0] = 1'b0;
    repeat (5)
      @(negedge clock);
    rd(acs_pkg::SEL_EXT_STATUS, acs_pkg::STS_WAIT_STOP, 1'b1);
    axis_running = 4'h0;
    idle_wait;
    check("queue", exp_q.size(), 0);
    // each source axis, wrong one first
    for (k = 0; k < 4; k++)
    begin
      wr(acs_pkg::SEL_SYNC_ENV, k << 20);
      arm(32'h1, 32'h0008_0041, 1'b0, 1, 1'b0);
      sync_bus = 4'h1 << ((k + 1) % 4);
      @(negedge clock);
      sync_bus = 4'h0;
      rd(acs_pkg::SEL_EXT_STATUS, acs_pkg::STS_WAIT_SYNC, 1'b1);
      sync_bus = 4'h1 << k;
      @(negedge clock);
      sync_bus = 4'h0;
      idle_wait;
    end
    wr(acs_pkg::SEL_IRQ_EN, 32'h0000_2000);
    for (k = 1; k < 12; k++)
    begin
      wr(acs_pkg::SEL_SYNC_ENV, k << 16);
      e = sync_cnt + ((k < 6 || k > 7) ? 1 : 0);
      if (k < 6)
      begin
        cmp_hit = 5'h01 << (k - 1);
        @(negedge clock);
        cmp_hit = 5'h00;
      end
      move(2'h0, 12'h000, 32'h1, 32'h41, 0, 1, 1'b0, 1'b0);
      check("sync count", sync_cnt, e);
    end
    check("irq", irq_out, 1'b1);
    rd(acs_pkg::SEL_EVT_FACTOR, acs_pkg::IRQ_SYNC_BIT, 1'b1);
    repeat (3)
      @(negedge clock);
    check("irq", irq_out, 1'b0);
    rd(4'he, 0, 1'b0);
    wr(acs_pkg::SEL_HS_RATE, 32'h0000_0014);
    arm(32'h5, 32'h41, 1'b0, 5, 1'b0);
    wr(acs_pkg::SEL_NEXT_TARGET, 32'h2);
    wr(acs_pkg::SEL_NEXT_MODE, 32'h41);
    push(1'b0, 4'hf, 2);
    wr(acs_pkg::SEL_START, 32'h0000_0000);
    rd(acs_pkg::SEL_EXT_STATUS, acs_pkg::STS_NEXT, 1'b1);
    idle_wait;
    check("queue", exp_q.size(), 0);
    check("position", position, exp_pos);
    tally_and_finish;
  end
endmodule // test_acs_axis
`default_nettype wire
